// ---- design/lsd_rx.sv ----
// Soft serial receiver with bitslip alignment and output FIFO

// ------------------------------------------------------------------
// Two-flop synchroniser
// ------------------------------------------------------------------
module lsd_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o <= '0;
    end else if (en_i) begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ------------------------------------------------------------------
// Flip-flop FIFO
// ------------------------------------------------------------------
module lsd_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
              (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = wr_ptr == rd_ptr;
  wire do_wr = in_valid_i && !full;
  wire do_rd = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (en_i && do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (en_i) begin
      if (flush_i) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (do_wr) wr_ptr <= wr_ptr + 1'b1;
        if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------------
// Receiver top
// ------------------------------------------------------------------
module lsd_rx
  import lsd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  // Configuration
  input wire logic ext_pll_i,
  // Link pins
  input wire logic link_clk_i,
  input wire logic sync_clk_i,
  input wire logic [NUM_CH-1:0] serial_i,
  input wire logic [NUM_CH-1:0] core_clk_i,
  // Resets
  input wire logic data_reset_i,
  input wire logic align_reset_i,
  input wire logic [NUM_CH-1:0] chan_align_reset_i,
  // Alignment
  input wire logic align_i,
  input wire logic [NUM_CH-1:0] chan_align_i,
  // Parallel stream
  output logic [BUS_W-1:0] rx_out_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // Status
  output logic locked_o,
  output logic outclock_o,
  output logic overflow_o
);
  // ----------------------------------------------------------------
  // Factor check
  // ----------------------------------------------------------------
  if (!DF_LEGAL) begin : gen_bad_factor
    // Elaboration stops on a factor the receiver cannot build
    $error("deser_factor of six or nine cannot be built");
  end

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 3 * NUM_CH + NUM_CH + 6;
  logic [SYNC_W-1:0] sync_q;
  lsd_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .d_i({link_clk_i, sync_clk_i, data_reset_i, align_reset_i, align_i,
          ext_pll_i, serial_i, core_clk_i, chan_align_reset_i,
          chan_align_i}),
    .q_o(sync_q)
  );

  wire s_link = sync_q[SYNC_W-1];
  wire s_sclk = sync_q[SYNC_W-2];
  wire s_dreset = sync_q[SYNC_W-3];
  wire s_areset = sync_q[SYNC_W-4];
  wire s_align = sync_q[SYNC_W-5];
  wire s_ext = sync_q[SYNC_W-6];
  wire [NUM_CH-1:0] s_ser = sync_q[4*NUM_CH-1 -: NUM_CH];
  wire [NUM_CH-1:0] s_core = sync_q[3*NUM_CH-1 -: NUM_CH];
  wire [NUM_CH-1:0] s_creset = sync_q[2*NUM_CH-1 -: NUM_CH];
  wire [NUM_CH-1:0] s_calign = sync_q[NUM_CH-1:0];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic link_d;
  logic sclk_d;
  logic align_d;
  logic [NUM_CH-1:0] core_d;
  logic [NUM_CH-1:0] calign_d;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_d <= 1'b0;
      sclk_d <= 1'b0;
      align_d <= 1'b0;
      core_d <= '0;
      calign_d <= '0;
    end else if (en_i) begin
      link_d <= s_link;
      sclk_d <= s_sclk;
      align_d <= s_align;
      core_d <= s_core;
      calign_d <= s_calign;
    end
  end

  wire link_rise = s_link && !link_d;
  wire sclk_rise = s_sclk && !sclk_d;
  // Global pulse only honoured when its own reset is idle
  wire glob_slip = s_align && !align_d && !s_areset;
  wire [NUM_CH-1:0] core_rise = s_core & ~core_d;
  wire [NUM_CH-1:0] chan_slip = s_calign & ~calign_d;

  // ----------------------------------------------------------------
  // Bit counter and internal parallel clock
  // ----------------------------------------------------------------
  logic [BITCNT_W-1:0] bitcnt;
  wire bit_wrap = link_rise && (bitcnt == BIT_LAST);
  // Odd factors frame the word on the sync clock instead
  wire int_strobe = DF_ODD ? sclk_rise : bit_wrap;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bitcnt <= '0;
      outclock_o <= 1'b0;
    end else if (en_i) begin
      if (s_dreset) begin
        bitcnt <= '0;
      end else if (link_rise) begin
        bitcnt <= bit_wrap ? '0 : bitcnt + 1'b1;
      end
      // Absent in external mode: held low
      outclock_o <= !s_ext && (bitcnt < BIT_HALF);
    end
  end

  // ----------------------------------------------------------------
  // Per-channel shift, slip and hold
  // ----------------------------------------------------------------
  logic [SHREG_W-1:0] shreg [NUM_CH];
  logic [OFF_W-1:0] offset [NUM_CH];
  logic [DESER_FACTOR-1:0] hold [NUM_CH];
  logic [BUS_W-1:0] next_bus;
  logic [NUM_CH-1:0] strobe;

  for (genvar c = 0; c < NUM_CH; c++) begin : gen_ch
    wire [SHREG_W-1:0] next_sh = {shreg[c][SHREG_W-2:0], s_ser[c]};
    // Off a bit edge the pin is not part of the word yet
    wire [SHREG_W-1:0] cur_sh = link_rise ? next_sh : shreg[c];
    wire [DESER_FACTOR-1:0] word =
      cur_sh[offset[c] +: DESER_FACTOR];
    wire slip = glob_slip || chan_slip[c];
    wire [OFF_W-1:0] next_off =
      (offset[c] == ROLL_LAST) ? OFF_RESET : offset[c] + 1'b1;
    wire [DESER_FACTOR-1:0] next_hold = strobe[c] ? word : hold[c];

    assign strobe[c] = s_ext ? core_rise[c] : int_strobe;
    // Lane c lands in slice c of the bus
    assign next_bus[c*DESER_FACTOR +: DESER_FACTOR] =
      next_hold;

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        shreg[c] <= '0;
        hold[c] <= '0;
      end else if (en_i) begin
        if (s_dreset) begin
          shreg[c] <= '0;
          hold[c] <= '0;
        end else begin
          if (link_rise) shreg[c] <= next_sh;
          hold[c] <= next_hold;
        end
      end
    end

    // Realignment state survives the data reset on purpose
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        offset[c] <= OFF_RESET;
      end else if (en_i) begin
        if (s_creset[c] || s_areset) begin
          offset[c] <= OFF_RESET;
        end else if (slip) begin
          offset[c] <= next_off;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output FIFO
  // ----------------------------------------------------------------
  // Channel 0 frames the bus; a full FIFO drops the word
  wire push = strobe[0] && !s_dreset;
  wire fifo_ready;
  wire fifo_valid;
  wire [BUS_W-1:0] fifo_data;
  wire pop = fifo_valid && (!rx_valid_o || rx_ready_i);

  lsd_fifo #(.WIDTH(BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .flush_i(s_dreset),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(next_bus),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_out_o <= '0;
      rx_valid_o <= 1'b0;
      overflow_o <= 1'b0;
    end else if (en_i) begin
      if (s_dreset) begin
        rx_valid_o <= 1'b0;
        overflow_o <= 1'b0;
      end else begin
        if (pop) begin
          rx_out_o <= fifo_data;
          rx_valid_o <= 1'b1;
        end else if (rx_ready_i) begin
          rx_valid_o <= 1'b0;
        end
        if (push && !fifo_ready) overflow_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock detection
  // ----------------------------------------------------------------
  // Lock is judged from link clock activity; data reset leaves it alone
  logic [LOCK_W-1:0] idle_cnt;
  logic [LOCK_W-1:0] edge_cnt;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt <= '0;
      edge_cnt <= '0;
      locked_o <= 1'b0;
    end else if (en_i) begin
      if (link_rise) begin
        idle_cnt <= '0;
        if (edge_cnt != LOCK_NEED) edge_cnt <= edge_cnt + 1'b1;
      end else if (idle_cnt == LOCK_TMO) begin
        edge_cnt <= '0;
      end else begin
        idle_cnt <= idle_cnt + 1'b1;
      end
      locked_o <= (edge_cnt == LOCK_NEED) &&
                  (idle_cnt != LOCK_TMO);
    end
  end
endmodule

// ---- pkg/lsd_pkg.sv ----
// Constants shared by the soft serial receiver
// Behaviour
// - Lane zero fills lowest output slice upward
// - Lock output high while clock locked
// - Each channel word is deser_factor bits wide
// - Parallel clock out only in internal mode
// - One core clock input per channel
// - Global align input slips all channels
// - Align reset clears global alignment state
// - Per-channel align input slips one channel
// - Per-channel reset clears its realignment
// - Even factor ignores synchronization clock
// - Factor values six and nine rejected
// - Each rising align edge slips one bit
// - Offset wraps to zero after rollover pulses
// - Data reset clears receive logic, not lock
package lsd_pkg;
  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned DESER_FACTOR = 8;
  localparam int unsigned BITSLIP_ROLLOVER = 8;
  localparam int unsigned OFF_W = 4;
  localparam int unsigned SHREG_W = DESER_FACTOR + 10;
  localparam int unsigned BUS_W = NUM_CH * DESER_FACTOR;
  localparam int unsigned BITCNT_W = 4;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [OFF_W-1:0] OFF_RESET = 4'h0;
  localparam logic [OFF_W-1:0] ROLL_LAST = OFF_W'(BITSLIP_ROLLOVER - 1);
  localparam logic [BITCNT_W-1:0] BIT_LAST = BITCNT_W'(DESER_FACTOR - 1);
  localparam logic [BITCNT_W-1:0] BIT_HALF = BITCNT_W'(DESER_FACTOR / 2);
  localparam bit DF_ODD = (DESER_FACTOR % 2) == 1;
  localparam bit DF_LEGAL = (DESER_FACTOR != 6) && (DESER_FACTOR != 9);
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned LOCK_TIMEOUT_NS = 1000;
  localparam int unsigned LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_EDGES = 16;
  localparam int unsigned LOCK_W = 6;
  localparam logic [LOCK_W-1:0] LOCK_TMO = LOCK_W'(LOCK_TIMEOUT_CYC);
  localparam logic [LOCK_W-1:0] LOCK_NEED = LOCK_W'(LOCK_EDGES);
endpackage

// ---- verif/lsd_rx_props.sv ----
// Port-level checks of the soft serial receiver
module lsd_rx_props
  import lsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Inputs
  input wire logic ext_pll_i,
  input wire logic link_clk_i,
  input wire logic data_reset_i,
  input wire logic rx_ready_i,
  // Outputs
  input wire logic [BUS_W-1:0] rx_out_o,
  input wire logic rx_valid_o,
  input wire logic locked_o,
  input wire logic outclock_o,
  input wire logic overflow_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Link activity counters
  // ----
  logic link_q;
  logic [7:0] idle, first, run;
  wire link_rise = link_clk_i && !link_q;
  wire [7:0] next_idle = link_rise ? 8'h00 : idle + 8'(idle != 8'hFF);
  wire [7:0] next_first = first + 8'(link_rise && first != 8'hFF);
  // Stricter gap than the design so a restart here never lags it
  wire [7:0] next_run = idle > 8'h1D ? 8'h00 :
    run + 8'(link_rise && run != 8'hFF);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_q <= 1'b0;
      idle <= 8'h00;
      first <= 8'h00;
      run <= 8'h00;
    end else begin
      link_q <= link_clk_i;
      idle <= next_idle;
      first <= next_first;
      run <= next_run;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  ext_outclk_a: assert property (ext_pll_i [*5] |-> !outclock_o)
    else $error("outclock in external mode");
  hold_word_a: assert property ((!data_reset_i [*4]) ##0
    (rx_valid_o && !rx_ready_i) |=> rx_valid_o && $stable(rx_out_o))
    else $error("held word changed");
  drop_word_a: assert property ($fell(rx_valid_o) |->
    $past(rx_ready_i) || $past(data_reset_i, 2) || $past(data_reset_i, 3))
    else $error("word lost unaccepted");
  dreset_clr_a: assert property (data_reset_i [*5] |->
    !rx_valid_o && !overflow_o) else $error("stream kept in reset");
  dreset_lock_a: assert property (data_reset_i && locked_o &&
    idle < 8'h1E |=> locked_o) else $error("lock lost in data reset");
  rst_zero_a: assert property ($rose(rstn_i) |-> !rx_valid_o &&
    !locked_o && !overflow_o) else $error("outputs set after reset");
  idle_unlock_a: assert property (idle > 8'h2E |-> !locked_o)
    else $error("lock on idle link");
  early_lock_a: assert property (first < 8'h10 |-> !locked_o)
    else $error("lock too early");
  run_lock_a: assert property (run > 8'h13 |-> locked_o)
    else $error("no lock on busy link");
  cover property ($rose(overflow_o));
  cover property (rx_valid_o && rx_ready_i);
  cover property ($rose(locked_o));
endmodule

// ---- verif/lsd_tx_model.sv ----
// Remote serial transmitter model for the receiver link pins
module lsd_tx_model
  import lsd_pkg::*;
(
  // Link pins
  output logic link_clk_o,
  output logic [NUM_CH-1:0] serial_o,
  output logic [NUM_CH-1:0] core_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk_o = 1'b0;
    serial_o = '0;
    core_clk_o = '0;
  end
  // Clock stands low between frames; data moves on the falling edge
  task automatic send(input logic [BUS_W-1:0] w);
    #13;
    for (int i = DESER_FACTOR - 1; i >= 0; i--) begin
      for (int c = 0; c < NUM_CH; c++)
        serial_o[c] = w[c*DESER_FACTOR+i];
      #100 link_clk_o = 1'b1;
      #100 link_clk_o = 1'b0;
    end
    serial_o = ~serial_o;
    // Lane 0 last, so the bus picks up fresh words of the others
    core_clk_o[NUM_CH-1:1] = '1;
    #50 core_clk_o[0] = 1'b1;
    #100 core_clk_o = '0;
  endtask
endmodule

// ---- verif/test_lsd_rx.sv ----
// Self-checking bench for the soft serial receiver
bind lsd_rx lsd_rx_props chk_u (.clk_i, .rstn_i, .ext_pll_i,
  .link_clk_i, .data_reset_i, .rx_ready_i, .rx_out_o, .rx_valid_o,
  .locked_o, .outclock_o, .overflow_o);

module test_lsd_rx
  import lsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int D = DESER_FACTOR;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ext_pll_i = 1'b0;
  logic sync_clk_i = 1'b0;
  logic data_reset_i = 1'b0;
  logic align_reset_i = 1'b0;
  logic align_i = 1'b0;
  logic rx_ready_i = 1'b0;
  logic [NUM_CH-1:0] chan_align_reset_i = '0;
  logic [NUM_CH-1:0] chan_align_i = '0;
  logic link_clk;
  logic [NUM_CH-1:0] serial, core_clk;
  logic [BUS_W-1:0] rx_out_o;
  logic rx_valid_o, locked_o, outclock_o, overflow_o;
  logic [BUS_W-1:0] prev = '0;
  logic [BUS_W-1:0] exp_q [$];
  logic [OFF_W-1:0] off [NUM_CH] = '{default: '0};
  int failures = 0;
  int check_count = 0;
  int k = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) sync_clk_i <= #2 ~sync_clk_i;
  lsd_tx_model tx_u (.link_clk_o(link_clk), .serial_o(serial),
    .core_clk_o(core_clk));
  lsd_rx dut_u (.clk_i, .rstn_i, .en_i(1'b1), .ext_pll_i,
    .link_clk_i(link_clk), .sync_clk_i, .serial_i(serial),
    .core_clk_i(core_clk), .data_reset_i, .align_reset_i,
    .chan_align_reset_i, .align_i, .chan_align_i, .rx_out_o,
    .rx_valid_o, .rx_ready_i, .locked_o, .outclock_o, .overflow_o);
  // ----
  // Access tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [BUS_W-1:0] got,
                     input logic [BUS_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [BUS_W-1:0] pat(input int i);
    return {8'(i), 8'(i ^ 8'h5A), 8'(~i), 8'(i + 8'h31)};
  endfunction
  // Expected word: older bits enter as the boundary slips
  task automatic put(input logic [BUS_W-1:0] w);
    logic [BUS_W-1:0] e;
    for (int c = 0; c < NUM_CH; c++)
      e[c*D+:D] = D'({prev[c*D+:D], w[c*D+:D]} >> off[c]);
    exp_q.push_back(e);
    prev = w;
    tx_u.send(w);
    tick(1);
  endtask
  task automatic get();
    int n;
    n = 0;
    while (rx_valid_o !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) begin
      failures++;
      end_of_test();
    end
    cmp(rx_out_o, exp_q.pop_front());
    rx_ready_i = 1'b1;
    tick(1);
    rx_ready_i = 1'b0;
  endtask
  task automatic pair();
    put(pat(k));
    put(pat(k + 1));
    get();
    get();
    k += 2;
  endtask
  // Pulses outlast one parallel word of 64 cycles
  task automatic slip(input logic [NUM_CH-1:0] ch, input logic g,
                      input logic r);
    {chan_align_reset_i, align_reset_i} = r ? {ch, g} : '0;
    {chan_align_i, align_i} = r ? '0 : {ch, g};
    tick(70);
    {chan_align_reset_i, align_reset_i, chan_align_i, align_i} = '0;
    tick(70);
    for (int c = 0; c < NUM_CH; c++)
      if (ch[c] || g)
        off[c] = (r || off[c] == ROLL_LAST) ? '0 : off[c] + 4'h1;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    tick(6);
    rstn_i = 1'b1;
    tick(3);
    for (int i = 0; i < 35; i++) put(pat(i));
    tick(5);
    cmp(32'(overflow_o), 32'h1);
    cmp(32'(locked_o), 32'h1);
    cmp(32'(outclock_o), 32'h1);
    repeat (33) get();
    exp_q.delete();
    tick(10);
    cmp(32'({rx_valid_o, locked_o}), 32'h0);
    for (int i = 0; i < 3; i++) put(pat(i + 40));
    data_reset_i = 1'b1;
    tick(6);
    data_reset_i = 1'b0;
    tick(4);
    cmp(32'({rx_valid_o, overflow_o, locked_o}), 32'h1);
    exp_q.delete();
    prev = '0;
    slip(4'h1, 1'b0, 1'b0);
    repeat (3) slip(4'h4, 1'b0, 1'b0);
    slip(4'h0, 1'b1, 1'b0);
    pair();
    repeat (7) slip(4'h0, 1'b1, 1'b0);
    pair();
    slip(4'h4, 1'b0, 1'b1);
    pair();
    slip(4'h0, 1'b1, 1'b1);
    pair();
    ext_pll_i = 1'b1;
    tick(5);
    pair();
    cmp(32'(outclock_o), 32'h0);
    end_of_test();
  end
endmodule
